// ===== logic/tbc_boot.sv
// Start-up path selection and locked identification store for the key transponder.
// What this block does
// - Option bit five picks secret key
// - Option bit six enables protected key loading
// - Authentication uses the key that choice names
// - Option bit seven enables detection header
// - Header sent only when enabled
// - Locked default key occupies 0x81B to 0x82A
// - Field reads of default key refused
// - Default key ciphers protected key loading
// - Serial stored high byte first, read-serial returns it
// - Customer code may follow the serial
// - Traceability bytes are read only
// - Byte 0x80F gives firmware version
// - Start-up runs after every reset source
// - Reset returns all state to initial
// - Reset always starts at boot vector
// - After delay, field check comes first
// - Field present skips checks, runs immobilizer
// - No field: no init, then application
// - Enhanced mode detection is ignored
// - Init acknowledges field, clocks, power, vectors, watchdog, link
// - Header alternates Manchester ones until field gap while coil damped
`default_nettype none
module tbc_boot #(
   parameter logic [31:0] SERIAL = 32'h0000_0000,
   parameter logic [7:0] CUSTOMER = 8'h00,
   parameter logic [7:0] PART_TYPE = 8'h00, // Arbitrary value.
   parameter logic [23:0] LOT = 24'h00_0000,
   parameter logic [7:0] SLICE = 8'h00,
   parameter logic [15:0] DIE = 16'h0000,
   parameter logic [7:0] FIRMWARE = 8'h00,
   parameter logic [119:0] DEFAULT_KEY = 120'h0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] reset_cause_i,
   input wire logic field_present_i,
   input wire logic field_gap_i,
   input wire logic [7:0] option_byte_i,
   input wire logic [127:0] key_area_one_i,
   input wire logic [127:0] key_area_two_i,
   input wire logic rd_req_i,
   input wire logic rd_from_field_i,
   input wire logic [11:0] rd_addr_i,
   input wire logic serial_with_customer_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic rd_refused_o,
   output logic boot_vector_o,
   output logic immo_mode_o,
   output logic app_mode_o,
   output logic header_mod_o,
   output logic [127:0] auth_key_o,
   output logic [127:0] transfer_key_o,
   output logic protected_key_load_o,
   output tbc_pkg::tbc_init_s init_steps_o
);
   typedef struct packed {
      tbc_pkg::tbc_state_e st;
      logic [9:0] cnt;
      logic [1:0] sync_field;
      logic [1:0] sync_gap;
      tbc_pkg::tbc_options_s opt;
      tbc_pkg::tbc_init_s init;
      logic [2:0] step;
      logic mod;
      logic [7:0] data;
      logic valid;
      logic refused;
   } tbc_reg_s;

   tbc_reg_s state_reg;
   tbc_reg_s state_next;
   logic [127:0] default_key;

   function automatic logic [7:0] tbc_id_byte(input logic [11:0] a, input logic with_cust);
      logic [7:0] b;
      b = 8'h00;
      case (a)
         12'h800: b = SERIAL[31:24];
         12'h801: b = SERIAL[23:16];
         12'h802: b = SERIAL[15:8];
         12'h803: b = SERIAL[7:0];
         12'h804: b = with_cust ? CUSTOMER : 8'h00;
         12'h808: b = PART_TYPE;
         12'h809: b = LOT[23:16];
         12'h80A: b = LOT[15:8];
         12'h80B: b = LOT[7:0];
         12'h80C: b = SLICE;
         12'h80D: b = DIE[15:8];
         12'h80E: b = DIE[7:0];
         12'h80F: b = FIRMWARE;
         default: b = 8'h00;
      endcase
      return b;
   endfunction : tbc_id_byte

   // Customer code heads the locked default key.
   assign default_key = {CUSTOMER, DEFAULT_KEY};

   always_comb begin
      state_next = state_reg;
      state_next.sync_field = {state_reg.sync_field[0], field_present_i};
      state_next.sync_gap = {state_reg.sync_gap[0], field_gap_i};
      state_next.valid = 1'b0;
      state_next.refused = 1'b0;
      if (rd_req_i) begin
         // The key is never on the field path, whatever the state.
         if (rd_from_field_i && rd_addr_i >= tbc_pkg::ADDR_KEY_FIRST
             && rd_addr_i <= tbc_pkg::ADDR_KEY_LAST) begin
            state_next.refused = 1'b1;
            state_next.data = 8'h00;
         end else begin
            state_next.valid = 1'b1;
            if (rd_addr_i == tbc_pkg::ADDR_OPTION) begin
               state_next.data = {state_reg.opt.channel_header_enable,
                  state_reg.opt.protected_key_load, state_reg.opt.key_choice, 5'h00};
            end else begin
               state_next.data = tbc_id_byte(rd_addr_i, serial_with_customer_i);
            end
         end
      end
      case (state_reg.st)
         tbc_pkg::TBC_DELAY: begin
            state_next.cnt = state_reg.cnt + 10'h001;
            if (state_reg.cnt == 10'(tbc_pkg::RESET_DELAY_CYC - 1)) begin
               state_next.st = tbc_pkg::TBC_FIELD_CHECK;
            end
         end
         tbc_pkg::TBC_FIELD_CHECK: begin
            state_next.opt.key_choice = option_byte_i[tbc_pkg::OPT_KEY_CHOICE];
            state_next.opt.protected_key_load = option_byte_i[tbc_pkg::OPT_PROTECTED_LOAD];
            state_next.opt.channel_header_enable =
               option_byte_i[tbc_pkg::OPT_HEADER_ENABLE];
            state_next.cnt = 10'h000;
            if (state_reg.sync_field[1]) begin
               state_next.st = tbc_pkg::TBC_INIT;
            end else begin
               state_next.st = tbc_pkg::TBC_ENHANCED_SKIP;
            end
         end
         tbc_pkg::TBC_ENHANCED_SKIP: begin
            // The enhanced-mode step does nothing on this part.
            state_next.st = tbc_pkg::TBC_APP;
         end
         tbc_pkg::TBC_INIT: begin
            // One step per cycle, in the listed order, so software sees each settle.
            state_next.step = state_reg.step + 3'h1;
            case (state_reg.step)
               3'h0: state_next.init.field_ack = 1'b1;
               3'h1: state_next.init.clocks_reconfig = 1'b1;
               3'h2: state_next.init.low_power = 1'b1;
               3'h3: state_next.init.vectors_to_boot = 1'b1;
               3'h4: state_next.init.watchdog_start = 1'b1;
               default: state_next.init.link_init = 1'b1;
            endcase
            if (state_reg.step == 3'(tbc_pkg::INIT_STEPS - 1)) begin
               state_next.st = state_reg.opt.channel_header_enable ?
                  tbc_pkg::TBC_HEADER : tbc_pkg::TBC_IMMO;
            end
         end
         tbc_pkg::TBC_HEADER: begin
            // Alternating half bits give a run of Manchester ones at the carrier rate.
            // The counter is wide enough for a full half bit at the carrier rate.
            if (state_reg.cnt == 10'(tbc_pkg::HALF_BIT_CYC - 1)) begin
               state_next.cnt = 10'h000;
               state_next.mod = ~state_reg.mod;
            end else begin
               state_next.cnt = state_reg.cnt + 10'h001;
            end
            // A gap only ends the header while the coil is damped.
            if (state_reg.sync_gap[1] && state_reg.mod) begin
               state_next.mod = 1'b0;
               state_next.st = tbc_pkg::TBC_IMMO;
            end
         end
         tbc_pkg::TBC_IMMO: begin
            state_next.st = tbc_pkg::TBC_IMMO;
         end
         tbc_pkg::TBC_APP: begin
            state_next.st = tbc_pkg::TBC_APP;
         end
         default: begin
            state_next.st = tbc_pkg::TBC_DELAY;
         end
      endcase
   end

   // Every reset source lands here, so one synchronous reset covers all causes.
   always_ff @(posedge clk_i) begin
      if (rst_i || reset_cause_i != 4'h0) begin
         state_reg <= '0;
         state_reg.st <= tbc_pkg::TBC_DELAY;
         state_reg.opt <= tbc_pkg::tbc_options_s'(3'h0);
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_data_o = state_reg.data;
   assign rd_valid_o = state_reg.valid;
   assign rd_refused_o = state_reg.refused;
   assign boot_vector_o = state_reg.st != tbc_pkg::TBC_APP;
   assign immo_mode_o = state_reg.st == tbc_pkg::TBC_IMMO
      || state_reg.st == tbc_pkg::TBC_HEADER;
   assign app_mode_o = state_reg.st == tbc_pkg::TBC_APP;
   assign header_mod_o = state_reg.mod;
   assign init_steps_o = state_reg.init;
   assign auth_key_o = state_reg.opt.key_choice ? key_area_two_i : key_area_one_i;
   assign protected_key_load_o = state_reg.opt.protected_key_load;
   assign transfer_key_o = state_reg.opt.protected_key_load ? default_key : 128'h0;
endmodule : tbc_boot
`default_nettype wire

// ===== logic/tbc_pkg.sv
// Package with constants and carrier types for the transponder boot configuration block.
`default_nettype none
package tbc_pkg;
   localparam logic [11:0] ADDR_SERIAL = 12'h800;
   localparam logic [11:0] ADDR_SERIAL_LAST = 12'h803;
   localparam logic [11:0] ADDR_CUSTOMER = 12'h804;
   localparam logic [11:0] ADDR_PART_TYPE = 12'h808;
   localparam logic [11:0] ADDR_LOT = 12'h809;
   localparam logic [11:0] ADDR_LOT_LAST = 12'h80B;
   localparam logic [11:0] ADDR_SLICE = 12'h80C;
   localparam logic [11:0] ADDR_DIE = 12'h80D;
   localparam logic [11:0] ADDR_DIE_LAST = 12'h80E;
   localparam logic [11:0] ADDR_FIRMWARE = 12'h80F;
   localparam logic [11:0] ADDR_OPTION = 12'h815;
   localparam logic [11:0] ADDR_KEY_FIRST = 12'h81B;
   localparam logic [11:0] ADDR_KEY_LAST = 12'h82A;
   localparam int OPT_KEY_CHOICE = 5;
   localparam int OPT_PROTECTED_LOAD = 6;
   localparam int OPT_HEADER_ENABLE = 7;
   localparam logic [7:0] OPTION_RESET = 8'h00;
   localparam int RESET_DELAY_NS = 64;
   localparam int CLK_PERIOD_NS = 4;
   localparam int RESET_DELAY_CYC =
      (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CARRIER_HZ = 125000;
   localparam int CLK_HZ = 250000000;
   localparam int HALF_BIT_CYC = CLK_HZ / CARRIER_HZ / 2;
   localparam int INIT_STEPS = 6;

   typedef enum logic [3:0] {
      TBC_DELAY, TBC_FIELD_CHECK, TBC_ENHANCED_SKIP, TBC_INIT,
      TBC_HEADER, TBC_IMMO, TBC_APP
   } tbc_state_e;

   typedef struct packed {
      logic key_choice;
      logic protected_key_load;
      logic channel_header_enable;
   } tbc_options_s;

   typedef struct packed {
      logic field_ack;
      logic clocks_reconfig;
      logic low_power;
      logic vectors_to_boot;
      logic watchdog_start;
      logic link_init;
   } tbc_init_s;
endpackage : tbc_pkg
`default_nettype wire

// ===== verification/tbc_base_station.sv
// Behavioural base station that powers the transponder through the field.
`default_nettype none
module tbc_base_station (
   input wire logic clk_i,
   input wire logic field_on_i,
   input wire logic header_mod_i,
   output var logic field_present_o = 1'b0,
   output var logic field_gap_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned seen = 0;
   // The gap is cut only in a damped phase, so an undamped gap shows a fault.
   always @(posedge clk_i) begin
      field_present_o <= field_on_i;
      seen <= field_on_i ? seen + 32'(header_mod_i) : 0;
      field_gap_o <= field_on_i && header_mod_i && seen > 1500;
   end
endmodule : tbc_base_station
`default_nettype wire

// ===== verification/tbc_boot_checker.sv
// Assertions on the ports of the boot block.
`default_nettype none
module tbc_boot_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] reset_cause_i,
   input wire logic rd_req_i,
   input wire logic rd_from_field_i,
   input wire logic [11:0] rd_addr_i,
   input wire logic [7:0] rd_data_o,
   input wire logic rd_valid_o,
   input wire logic rd_refused_o,
   input wire logic boot_vector_o,
   input wire logic immo_mode_o,
   input wire logic app_mode_o,
   input wire logic header_mod_o,
   input wire logic [127:0] transfer_key_o,
   input wire logic protected_key_load_o,
   input wire tbc_pkg::tbc_init_s init_steps_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i || reset_cause_i != 4'h0);
   logic key_rd;
   assign key_rd = rd_req_i && rd_addr_i >= 12'h81B && rd_addr_i <= 12'h82A;
   sequence s_init;
      init_steps_o == 6'h20 ##1 init_steps_o == 6'h30 ##1 init_steps_o == 6'h38
      ##1 init_steps_o == 6'h3C ##1 init_steps_o == 6'h3E ##1 init_steps_o == 6'h3F;
   endsequence
   a_field_refuse: assert property (key_rd && rd_from_field_i |=> rd_refused_o &&
      !rd_valid_o && rd_data_o == 8'h00) else $error("field key read not refused");
   a_local_key: assert property (key_rd && !rd_from_field_i |=> rd_valid_o &&
      rd_data_o == 8'h00) else $error("local key read wrong");
   a_read_answer: assert property (rd_req_i && !key_rd |=> rd_valid_o && !rd_refused_o)
      else $error("read not answered");
   a_data_holds: assert property (!rd_req_i |=> $stable(rd_data_o))
      else $error("read data moved");
   a_reset_clear: assert property ($fell(rst_i) |-> boot_vector_o && !immo_mode_o &&
      !app_mode_o && init_steps_o == 6'h00) else $error("reset state wrong");
   a_delay_first: assert property ($fell(rst_i) |-> (!immo_mode_o && !app_mode_o &&
      init_steps_o == 6'h00) [*8]) else $error("start-up delay too short");
   a_init_order: assert property ($rose(init_steps_o.field_ack) |-> s_init)
      else $error("init steps out of order");
   a_app_clean: assert property (app_mode_o |-> init_steps_o == 6'h00 && !boot_vector_o
      && !header_mod_o) else $error("application entered dirty");
   a_header_after: assert property ($rose(header_mod_o) |-> init_steps_o == 6'h3F &&
      !app_mode_o) else $error("header before init");
   a_plain_key: assert property (!protected_key_load_o |-> transfer_key_o == 128'h0)
      else $error("transfer key leaked");
endmodule : tbc_boot_checker
bind tbc_boot tbc_boot_checker tbc_boot_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
   .reset_cause_i(reset_cause_i), .rd_req_i(rd_req_i), .rd_from_field_i(rd_from_field_i),
   .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
   .rd_refused_o(rd_refused_o), .boot_vector_o(boot_vector_o), .immo_mode_o(immo_mode_o),
   .app_mode_o(app_mode_o), .header_mod_o(header_mod_o), .transfer_key_o(transfer_key_o),
   .protected_key_load_o(protected_key_load_o), .init_steps_o(init_steps_o));
`default_nettype wire

// ===== verification/tb_tbc_boot.sv
// Self-checking bench for the boot block.
`default_nettype none
module tb_tbc_boot;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] SER = 32'h1234_5678;
   localparam logic [119:0] KEY = 120'hA5_0F;
   logic clk_i = 1'b0, rst_i = 1'b1, fon = 1'b0, rd_req_i = 1'b0, rd_from_field_i = 1'b0;
   logic serial_with_customer_i = 1'b0, fp, fg, rv, rr, bv, im, ap, hm, pl, pf, pw;
   logic [3:0] reset_cause_i = 4'h0;
   logic [7:0] option_byte_i = 8'h00, rd_data_o, cur;
   logic [11:0] rd_addr_i = 12'h800, pa;
   logic [127:0] k1 = 128'h11, k2 = 128'h22, ak, tk;
   tbc_pkg::tbc_init_s st;
   logic [15:0] seed = 16'h0001;
   int err_total = 0, cmp_count = 0, cyc = 0;
   always #2 clk_i = ~clk_i;
   // Identity parameters below are arbitrary values.
   tbc_boot #(.SERIAL(SER), .CUSTOMER(8'hC5), .PART_TYPE(8'h3A), .LOT(24'hABCDEF),
      .SLICE(8'h11), .DIE(16'h2233), .FIRMWARE(8'h44), .DEFAULT_KEY(KEY)) tbc_boot_inst (
      .clk_i(clk_i), .rst_i(rst_i), .reset_cause_i(reset_cause_i), .field_present_i(fp),
      .field_gap_i(fg), .option_byte_i(option_byte_i), .key_area_one_i(k1),
      .key_area_two_i(k2), .rd_req_i(rd_req_i), .rd_from_field_i(rd_from_field_i),
      .rd_addr_i(rd_addr_i), .serial_with_customer_i(serial_with_customer_i),
      .rd_data_o(rd_data_o), .rd_valid_o(rv), .rd_refused_o(rr), .boot_vector_o(bv),
      .immo_mode_o(im), .app_mode_o(ap), .header_mod_o(hm), .auth_key_o(ak),
      .transfer_key_o(tk), .protected_key_load_o(pl), .init_steps_o(st));
   tbc_base_station tbc_base_station_inst (.clk_i(clk_i), .field_on_i(fon),
      .header_mod_i(hm), .field_present_o(fp), .field_gap_o(fg));
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [7:0] exp_rd(logic [11:0] a, logic w);
      logic [127:0] id;
      id = {SER, w ? 8'hC5 : 8'h00, 24'h0, 8'h3A, 24'hABCDEF, 8'h11, 16'h2233, 8'h44};
      if (a[11:4] == 8'h80) return id[8 * (15 - a[3:0]) +: 8];
      return a == 12'h815 ? {cur[7:5], 5'h00} : 8'h00;
   endfunction : exp_rd
   task automatic chk(string n, logic [127:0] e, logic [127:0] s);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   // Resets through rst_i, or through one reset cause bit picked by opt[1:0] when by_cause is set.
   task automatic boot(logic [7:0] opt, logic f, logic by_cause);
      logic saw, gapped;
      saw = 1'b0;
      gapped = 1'b0;
      k1 <= {4{seed, ~seed}};
      k2 <= {8{lfsr(seed)}};
      rst_i <= !by_cause;
      reset_cause_i <= by_cause ? 4'h8 >> opt[1:0] : 4'h0;
      option_byte_i <= opt;
      fon <= f;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      reset_cause_i <= 4'h0;
      // A header boot waits for the gap to end it, so the gap path is exercised.
      for (int n = 0; n < 5000 && ap !== 1'b1
            && !(im === 1'b1 && (!(f && opt[7]) || (gapped && hm === 1'b0))); n++) begin
         @(posedge clk_i);
         saw |= hm === 1'b1;
         gapped |= fg === 1'b1;
      end
      cur = opt;
      chk("mode", !f, ap);
      chk("immo", f, im);
      chk("bootvec", f, bv);
      chk("init", f ? 6'h3F : 6'h00, st);
      chk("header", f && opt[7], saw);
      chk("prot", opt[6], pl);
      chk("auth", opt[5] ? k2 : k1, ak);
      chk("xfer", opt[6] ? {8'hC5, KEY} : 128'h0, tk);
      option_byte_i <= ~opt;
      repeat (3) @(posedge clk_i);
      chk("hold", opt[6], pl);
      chk("mod", 1'b0, hm);
   endtask : boot
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      repeat (2) @(posedge clk_i);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         boot({i[1], i[2], ~i[1], seed[4:0]}, i[0], i[1] ^ i[0]);
         $display("test boot %0d done", i);
      end
      for (int i = 0; i <= 48; i++) begin
         @(posedge clk_i);
         pa = rd_addr_i;
         pf = rd_from_field_i;
         pw = serial_with_customer_i;
         seed = lfsr(seed);
         rd_req_i <= i < 48;
         rd_addr_i <= 12'h800 + 12'(i);
         rd_from_field_i <= seed[0];
         serial_with_customer_i <= seed[1];
         #1;
         if (i > 0) chk("refused", pf && pa >= 12'h81B && pa <= 12'h82A, rr);
         if (i > 0) chk("valid", !(pf && pa >= 12'h81B && pa <= 12'h82A), rv);
         if (i > 0) chk("data", exp_rd(pa, pw), rd_data_o);
      end
      $display("test reads done");
      end_sim();
   end
endmodule : tb_tbc_boot
`default_nettype wire
